// *** core/adg_regs.svh ***
`ifndef ADG_REGS_SVH
`define ADG_REGS_SVH

// widths of a generator word and of the data memory data bus
`define ADG_WORD_W 14
`define ADG_BUS_W 16
`define ADG_EXT_W 2
`define ADG_SIGN_BIT 13

// register file shape
`define ADG_FILE_DEPTH 4
`define ADG_SEL_W 2
`define ADG_GEN_COUNT 2
`define ADG_FILE_COUNT 3

// generator that owns the bit-reverse output
`define ADG_REV_GEN 0

// modulus arithmetic width
`define ADG_SUM_W 16

// reset values
`define ADG_WORD_RST 14'h0000
`define ADG_BUS_RST 16'h0000
`define ADG_FLAG_RST 1'h0

`endif

// *** core/adg_pkg.sv ***
package adg_pkg;
  `include "adg_regs.svh"

  typedef logic [`ADG_WORD_W-1:0] adg_word_t;
  typedef logic [`ADG_BUS_W-1:0] adg_bus_t;
  typedef logic [`ADG_SEL_W-1:0] adg_sel_t;
  typedef logic [`ADG_SUM_W-1:0] adg_sum_t;
  typedef logic [`ADG_FILE_DEPTH*`ADG_WORD_W-1:0] adg_flat_t;

  typedef enum logic [1:0] {
    ADG_FILE_INDEX,
    ADG_FILE_MODIFY,
    ADG_FILE_LENGTH
  } adg_file_e;
endpackage

// *** core/adg_regfile.sv ***
`timescale 1ns/1ps
module adg_regfile #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4,
  parameter int SELW = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // write port a, wins on the same entry
  input wire logic aWrEn,
  input wire logic [SELW-1:0] aWrNum,
  input wire logic [WIDTH-1:0] aWrData,
  // write port b
  input wire logic bWrEn,
  input wire logic [SELW-1:0] bWrNum,
  input wire logic [WIDTH-1:0] bWrData,
  // all entries, straight from the flops
  output logic [DEPTH*WIDTH-1:0] rdFlat
);
  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : gEntry
      logic [WIDTH-1:0] word;
      logic [WIDTH-1:0] next_word;
      always_comb begin
        next_word = word;
        if (aWrEn && (int'(aWrNum) == e)) begin
          next_word = aWrData;
        end else if (bWrEn && (int'(bWrNum) == e)) begin
          next_word = bWrData;
        end
      end
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          word <= '0;
        end else begin
          word <= next_word;
        end
      end
      assign rdFlat[e*WIDTH +: WIDTH] = word;
    end
  endgenerate
endmodule

// *** core/adg_modulus.sv ***
`timescale 1ns/1ps
`include "adg_regs.svh"
module adg_modulus (
  // current index, step and paired length
  input adg_pkg::adg_word_t idx,
  input adg_pkg::adg_word_t step,
  input adg_pkg::adg_word_t len,
  // updated index
  output adg_pkg::adg_word_t nextIdx
);
  import adg_pkg::*;

  adg_word_t lenM1;
  adg_word_t mask;
  adg_word_t base;
  adg_word_t offs;
  adg_word_t linNext;
  adg_sum_t sumExt;
  adg_sum_t lenExt;
  adg_sum_t wrap;

  assign lenM1 = len - 14'h0001;

  // low n bits of the index, n smallest with len <= 2^n
  genvar i;
  generate
    for (i = 0; i < `ADG_WORD_W; i++) begin : gMask
      assign mask[i] = |lenM1[`ADG_WORD_W-1:i];
    end
  endgenerate

  assign base = idx & ~mask;
  assign offs = idx & mask;
  assign sumExt = {{`ADG_EXT_W{1'h0}}, offs} + {{`ADG_EXT_W{step[`ADG_SIGN_BIT]}}, step};
  assign lenExt = {{`ADG_EXT_W{1'h0}}, len};
  assign linNext = idx + step;

  always_comb begin
    wrap = sumExt;
    if (sumExt[`ADG_SUM_W-1]) begin
      wrap = sumExt + lenExt;
    end else if (sumExt >= lenExt) begin
      wrap = sumExt - lenExt;
    end
  end

  // zero length bypasses the modulus logic
  assign nextIdx = (len == `ADG_WORD_RST) ? linNext : (base | wrap[`ADG_WORD_W-1:0]);
endmodule

// *** core/adg_core.sv ***
// Function
// - two generators; first reverses, second reaches program memory
// - each generator: four index, modify, length words
// - indirect address is selected index contents
// - post-modify: index plus modify written back
// - index pairs only with own generator's modify
// - modify words are signed two's complement
// - paired length zero linear, otherwise circular
// - paired length feeds modulus on boundary crossing
// - registers use low 14 data bus bits
// - index and length reads zero upper bits
// - modify reads sign-extend bit 13 upward
// - circular next is wrapped offset plus base
// - reversal mirrors address, bit k from 13-k
// - reversal mode holds until bit cleared
// - written-back index stays in normal order
// - mode bit write or enable instruction sets
// - data memory data bus is 16 bits
`timescale 1ns/1ps
`include "adg_regs.svh"
module adg_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register access over the data memory data bus
  input wire logic regWrEn,
  input wire logic regRdEn,
  input adg_pkg::adg_file_e regFile,
  input wire logic regGen,
  input adg_pkg::adg_sel_t regNum,
  input adg_pkg::adg_bus_t dmdWrData,
  output adg_pkg::adg_bus_t dmdRdData,
  output logic dmdRdValid,
  // mode status word and reversal instruction
  input wire logic modeWrEn,
  input wire logic modeRevBit,
  input wire logic revEnaInstr,
  output logic revMode,
  // first generator access
  input wire logic g1Req,
  input adg_pkg::adg_sel_t g1IdxSel,
  input adg_pkg::adg_sel_t g1ModSel,
  output adg_pkg::adg_word_t g1DmAddr,
  output logic g1DmValid,
  // second generator access
  input wire logic g2Req,
  input adg_pkg::adg_sel_t g2IdxSel,
  input adg_pkg::adg_sel_t g2ModSel,
  input wire logic g2ToProgram,
  output adg_pkg::adg_word_t g2DmAddr,
  output logic g2DmValid,
  output adg_pkg::adg_word_t g2PmAddr,
  output logic g2PmValid
);
  import adg_pkg::*;

  // pick one word out of a flattened register file
  function automatic adg_word_t pickWord(input adg_flat_t flat, input adg_sel_t sel);
    pickWord = flat[sel*`ADG_WORD_W +: `ADG_WORD_W];
  endfunction

  // per-generator request view
  logic req [0:`ADG_GEN_COUNT-1];
  adg_sel_t idxSel [0:`ADG_GEN_COUNT-1];
  adg_sel_t modSel [0:`ADG_GEN_COUNT-1];

  assign req[0] = g1Req;
  assign req[1] = g2Req;
  assign idxSel[0] = g1IdxSel;
  assign idxSel[1] = g2IdxSel;
  assign modSel[0] = g1ModSel;
  assign modSel[1] = g2ModSel;

  // register file contents, by generator and file kind
  adg_flat_t fileFlat [0:`ADG_GEN_COUNT-1][0:`ADG_FILE_COUNT-1];

  // operands and results of each generator
  adg_word_t curIdx [0:`ADG_GEN_COUNT-1];
  adg_word_t curStep [0:`ADG_GEN_COUNT-1];
  adg_word_t curLen [0:`ADG_GEN_COUNT-1];
  adg_word_t updIdx [0:`ADG_GEN_COUNT-1];

  // first generator's index mirrored about its midpoint
  adg_word_t revIdx;
  genvar k;
  generate
    for (k = 0; k < `ADG_WORD_W; k++) begin : gMirror
      assign revIdx[k] = curIdx[`ADG_REV_GEN][`ADG_WORD_W-1-k];
    end
  endgenerate

  // registered address outputs
  adg_word_t addrOut [0:`ADG_GEN_COUNT-1];
  adg_word_t next_addrOut [0:`ADG_GEN_COUNT-1];
  logic addrValid [0:`ADG_GEN_COUNT-1];
  logic next_addrValid [0:`ADG_GEN_COUNT-1];
  logic pmTarget;
  logic next_pmTarget;

  // mode and read-back state
  logic next_revMode;
  adg_bus_t next_dmdRdData;
  logic next_dmdRdValid;
  adg_word_t rdWord;

  genvar g, f;
  generate
    for (g = 0; g < `ADG_GEN_COUNT; g++) begin : gGen
      for (f = 0; f < `ADG_FILE_COUNT; f++) begin : gFile
        logic busWr;
        logic updWr;

        // bus writes take the low word bits of the data bus
        assign busWr = regWrEn && (int'(regGen) == g) && (int'(regFile) == f);
        // only the index file takes the post-modify result
        assign updWr = req[g] && (f == int'(ADG_FILE_INDEX));

        adg_regfile #(
          .WIDTH(`ADG_WORD_W),
          .DEPTH(`ADG_FILE_DEPTH),
          .SELW(`ADG_SEL_W)
        ) uFile (
          .ref_clk(ref_clk),
          .rst_b(rst_b),
          .aWrEn(busWr),
          .aWrNum(regNum),
          .aWrData(dmdWrData[`ADG_WORD_W-1:0]),
          .bWrEn(updWr),
          .bWrNum(idxSel[g]),
          .bWrData(updIdx[g]),
          .rdFlat(fileFlat[g][f])
        );
      end

      // index and length share the index select, modify stays in its generator
      assign curIdx[g] = pickWord(fileFlat[g][ADG_FILE_INDEX], idxSel[g]);
      assign curStep[g] = pickWord(fileFlat[g][ADG_FILE_MODIFY], modSel[g]);
      assign curLen[g] = pickWord(fileFlat[g][ADG_FILE_LENGTH], idxSel[g]);

      adg_modulus uMod (
        .idx(curIdx[g]),
        .step(curStep[g]),
        .len(curLen[g]),
        .nextIdx(updIdx[g])
      );

      // address is taken before the update, mirrored only on the first generator
      always_comb begin
        next_addrOut[g] = addrOut[g];
        next_addrValid[g] = req[g];
        if (req[g]) begin
          if ((g == `ADG_REV_GEN) && revMode) begin
            next_addrOut[g] = revIdx;
          end else begin
            next_addrOut[g] = curIdx[g];
          end
        end
      end

      // address and index write-back land on the same edge
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          addrOut[g] <= `ADG_WORD_RST;
          addrValid[g] <= `ADG_FLAG_RST;
        end else begin
          addrOut[g] <= next_addrOut[g];
          addrValid[g] <= next_addrValid[g];
        end
      end
    end
  endgenerate

  // second generator steers to data or program memory
  always_comb begin
    next_pmTarget = pmTarget;
    if (g2Req) begin
      next_pmTarget = g2ToProgram;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pmTarget <= `ADG_FLAG_RST;
    end else begin
      pmTarget <= next_pmTarget;
    end
  end

  assign g1DmAddr = addrOut[0];
  assign g1DmValid = addrValid[0];
  assign g2DmAddr = addrOut[1];
  assign g2PmAddr = addrOut[1];
  assign g2DmValid = addrValid[1] && !pmTarget;
  assign g2PmValid = addrValid[1] && pmTarget;

  // reversal mode: instruction set wins over a clearing write
  always_comb begin
    next_revMode = revMode;
    if (modeWrEn) begin
      next_revMode = modeRevBit;
    end
    if (revEnaInstr) begin
      next_revMode = 1'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      revMode <= `ADG_FLAG_RST;
    end else begin
      revMode <= next_revMode;
    end
  end

  // register read-back onto the 16-bit data bus
  adg_word_t rdIdx;
  adg_word_t rdMod;
  adg_word_t rdLen;

  assign rdIdx = pickWord(fileFlat[regGen][ADG_FILE_INDEX], regNum);
  assign rdMod = pickWord(fileFlat[regGen][ADG_FILE_MODIFY], regNum);
  assign rdLen = pickWord(fileFlat[regGen][ADG_FILE_LENGTH], regNum);

  // the unused file code reads as zero
  always_comb begin
    rdWord = `ADG_WORD_RST;
    case (regFile)
      ADG_FILE_INDEX: begin
        rdWord = rdIdx;
      end
      ADG_FILE_MODIFY: begin
        rdWord = rdMod;
      end
      ADG_FILE_LENGTH: begin
        rdWord = rdLen;
      end
      default: begin
        rdWord = `ADG_WORD_RST;
      end
    endcase
  end

  always_comb begin
    next_dmdRdData = dmdRdData;
    next_dmdRdValid = regRdEn;
    if (regRdEn) begin
      if (regFile == ADG_FILE_MODIFY) begin
        next_dmdRdData = {{`ADG_EXT_W{rdWord[`ADG_SIGN_BIT]}}, rdWord};
      end else begin
        next_dmdRdData = {{`ADG_EXT_W{1'h0}}, rdWord};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dmdRdData <= `ADG_BUS_RST;
      dmdRdValid <= `ADG_FLAG_RST;
    end else begin
      dmdRdData <= next_dmdRdData;
      dmdRdValid <= next_dmdRdValid;
    end
  end
endmodule

// *** bench/adg_core_chk.sv ***
`timescale 1ns/1ps
module adg_core_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire logic regRdEn,
  input adg_pkg::adg_file_e regFile,
  input adg_pkg::adg_bus_t dmdRdData,
  input wire logic dmdRdValid,
  // mode
  input wire logic modeWrEn,
  input wire logic modeRevBit,
  input wire logic revEnaInstr,
  input wire logic revMode,
  // access
  input wire logic g1Req,
  input wire logic g1DmValid,
  input wire logic g2Req,
  input wire logic g2ToProgram,
  input adg_pkg::adg_word_t g2DmAddr,
  input wire logic g2DmValid,
  input adg_pkg::adg_word_t g2PmAddr,
  input wire logic g2PmValid
);
  import adg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_rdValid; regRdEn |=> dmdRdValid; endproperty
  a_rdValid: assert property (p_rdValid) else $error("read gave no valid");
  property p_rdSpur; !regRdEn |=> !dmdRdValid; endproperty
  a_rdSpur: assert property (p_rdSpur) else $error("valid without read");
  property p_pad; regRdEn && regFile != ADG_FILE_MODIFY |=> dmdRdData[15:14] == 2'h0; endproperty
  a_pad: assert property (p_pad) else $error("upper bits not zero");
  property p_ext; regRdEn && regFile == ADG_FILE_MODIFY |=> dmdRdData[15:14] == {2{dmdRdData[13]}};
  endproperty
  a_ext: assert property (p_ext) else $error("modify not sign extended");
  property p_g1; g1Req |=> g1DmValid; endproperty
  a_g1: assert property (p_g1) else $error("first address late");
  property p_g1Pulse; !g1Req |=> !g1DmValid; endproperty
  a_g1Pulse: assert property (p_g1Pulse) else $error("first valid without access");
  property p_g2Pulse; !g2Req |=> !g2DmValid && !g2PmValid; endproperty
  a_g2Pulse: assert property (p_g2Pulse) else $error("second valid without access");
  property p_revWr; modeWrEn && !revEnaInstr |=> revMode == $past(modeRevBit); endproperty
  a_revWr: assert property (p_revWr) else $error("mode bit write not taken");
  property p_pm; g2Req && g2ToProgram |=> g2PmValid && !g2DmValid; endproperty
  a_pm: assert property (p_pm) else $error("program target wrong");
  property p_dm; g2Req && !g2ToProgram |=> g2DmValid && !g2PmValid; endproperty
  a_dm: assert property (p_dm) else $error("data target wrong");
  property p_same; g2DmValid || g2PmValid |-> g2DmAddr == g2PmAddr; endproperty
  a_same: assert property (p_same) else $error("second addresses differ");
  property p_revOn; revEnaInstr |=> revMode; endproperty
  a_revOn: assert property (p_revOn) else $error("reversal not enabled");
  property p_revHold; !modeWrEn && !revEnaInstr |=> $stable(revMode); endproperty
  a_revHold: assert property (p_revHold) else $error("reversal mode drifted");
  c_rd: cover property (regRdEn ##1 dmdRdValid);
  c_pm: cover property (g2Req && g2ToProgram);
  c_rev: cover property (revMode && g1Req);
endmodule
bind adg_core adg_core_chk chk (.ref_clk, .rst_b, .regRdEn, .regFile, .dmdRdData, .dmdRdValid,
  .modeWrEn, .modeRevBit, .revEnaInstr, .revMode, .g1Req, .g1DmValid, .g2Req, .g2ToProgram,
  .g2DmAddr,
  .g2DmValid, .g2PmAddr, .g2PmValid);

// *** bench/adg_seq_model.sv ***
`timescale 1ns/1ps
module adg_seq_model (
  // clock
  input wire logic ref_clk,
  // first generator
  output logic g1Req,
  output adg_pkg::adg_sel_t g1IdxSel,
  output adg_pkg::adg_sel_t g1ModSel,
  input adg_pkg::adg_word_t g1DmAddr,
  input wire logic g1DmValid,
  // second generator
  output logic g2Req,
  output adg_pkg::adg_sel_t g2IdxSel,
  output adg_pkg::adg_sel_t g2ModSel,
  output logic g2ToProgram,
  input adg_pkg::adg_word_t g2DmAddr,
  input wire logic g2DmValid,
  input adg_pkg::adg_word_t g2PmAddr,
  input wire logic g2PmValid
);
  import adg_pkg::*;
  initial begin
    {g1Req, g2Req, g2ToProgram} = 3'h0;
    {g1IdxSel, g1ModSel, g2IdxSel, g2ModSel} = 8'h00;
  end
  // back-to-back accesses; lengths loaded first steps below length
  // circular starts on aligned bases reversal steps are powers of two
  task automatic burst(input logic gen, input adg_sel_t idx, input adg_sel_t md,
      input logic prog, input int n, output adg_word_t a [4], output logic ok);
    ok = 1'h1;
    @(posedge ref_clk);
    g1Req <= !gen;
    g2Req <= gen;
    {g1IdxSel, g2IdxSel} <= {idx, idx};
    {g1ModSel, g2ModSel} <= {md, md};
    g2ToProgram <= prog;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (i == n - 1) begin
        {g1Req, g2Req} <= 2'h0;
      end
      #1;
      a[i] = gen ? g2DmAddr : g1DmAddr;
      if (gen ? ({g2PmValid, g2DmValid} !== {prog, !prog}) || (g2DmAddr !== g2PmAddr)
          : (g1DmValid !== 1'h1)) ok = 1'h0;
    end
  endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import adg_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic regWrEn = 1'h0;
  logic regRdEn = 1'h0;
  adg_file_e regFile = ADG_FILE_INDEX;
  logic regGen = 1'h0;
  adg_sel_t regNum = 2'h0;
  adg_bus_t dmdWrData = 16'h0000;
  logic modeWrEn = 1'h0;
  logic modeRevBit = 1'h0;
  logic revEnaInstr = 1'h0;
  adg_bus_t dmdRdData;
  logic dmdRdValid, revMode, g1Req, g2Req, g2ToProgram, g1DmValid, g2DmValid, g2PmValid, ok;
  adg_sel_t g1IdxSel, g1ModSel, g2IdxSel, g2ModSel;
  adg_word_t g1DmAddr, g2DmAddr, g2PmAddr;
  adg_word_t seen [4];
  int nErrors = 0;
  int checked = 0;
  int cycles = 0;
  adg_core dut (.ref_clk, .rst_b, .regWrEn, .regRdEn, .regFile, .regGen, .regNum, .dmdWrData,
    .dmdRdData, .dmdRdValid, .modeWrEn, .modeRevBit, .revEnaInstr, .revMode, .g1Req,
    .g1IdxSel, .g1ModSel, .g1DmAddr, .g1DmValid, .g2Req, .g2IdxSel, .g2ModSel, .g2ToProgram,
    .g2DmAddr, .g2DmValid, .g2PmAddr, .g2PmValid);
  adg_seq_model model (.ref_clk, .g1Req, .g1IdxSel, .g1ModSel, .g1DmAddr, .g1DmValid, .g2Req,
    .g2IdxSel, .g2ModSel, .g2ToProgram, .g2DmAddr, .g2DmValid, .g2PmAddr, .g2PmValid);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      print_verdict;
    end
  end
  task automatic check(input adg_bus_t got, input adg_bus_t exp);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input adg_file_e f, input logic g, input adg_sel_t n,
      input adg_bus_t d);
    @(posedge ref_clk);
    {regWrEn, regRdEn} <= {w, !w};
    {regFile, regGen, regNum, dmdWrData} <= {f, g, n, d};
    @(posedge ref_clk);
    {regWrEn, regRdEn} <= 2'h0;
    #1;
    if (!w) check({15'h0000, dmdRdValid}, 16'h0001);
  endtask
  task automatic rd(input adg_file_e f, input logic g, input adg_sel_t n, input adg_bus_t e);
    acc(1'h0, f, g, n, 16'h0000);
    check(dmdRdData, e);
  endtask
  task automatic load(input logic g, input adg_sel_t n, input adg_bus_t i, input adg_bus_t m,
      input adg_bus_t l);
    acc(1'h1, ADG_FILE_INDEX, g, n, i);
    acc(1'h1, ADG_FILE_MODIFY, g, n, m);
    acc(1'h1, ADG_FILE_LENGTH, g, n, l);
  endtask
  task automatic burst(input logic g, input adg_sel_t i, input adg_sel_t m, input logic p,
      input int n, input adg_word_t e [4]);
    model.burst(g, i, m, p, n, seen, ok);
    check({15'h0000, ok}, 16'h0001);
    for (int k = 0; k < n; k++) check({2'h0, seen[k]}, {2'h0, e[k]});
  endtask
  task automatic mode(input logic w, input logic b, input logic i, input logic e);
    @(posedge ref_clk);
    {modeWrEn, modeRevBit, revEnaInstr} <= {w, b, i};
    @(posedge ref_clk);
    {modeWrEn, revEnaInstr} <= 2'h0;
    #1;
    check({15'h0000, revMode}, {15'h0000, e});
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'h1;
    load(1'h0, 2'h2, 16'hFFFF, 16'h2001, 16'h0000);
    load(1'h1, 2'h3, 16'h0000, 16'h5234, 16'hC00A);
    acc(1'h1, adg_file_e'(2'h3), 1'h1, 2'h3, 16'h3FFF);
    rd(adg_file_e'(2'h3), 1'h1, 2'h3, 16'h0000);
    rd(ADG_FILE_INDEX, 1'h0, 2'h2, 16'h3FFF);
    rd(ADG_FILE_MODIFY, 1'h0, 2'h2, 16'hE001);
    rd(ADG_FILE_LENGTH, 1'h1, 2'h3, 16'h000A);
    rd(ADG_FILE_MODIFY, 1'h1, 2'h3, 16'h1234);
    $display("test registers done");
    load(1'h0, 2'h1, 16'h0000, 16'h3FFF, 16'h0000);
    burst(1'h0, 2'h1, 2'h1, 1'h0, 2, '{14'h0000, 14'h3FFF, 14'h0, 14'h0});
    load(1'h0, 2'h0, 16'h0005, 16'h0001, 16'h0003);
    burst(1'h0, 2'h0, 2'h0, 1'h0, 4, '{14'h5, 14'h6, 14'h4, 14'h5});
    burst(1'h0, 2'h0, 2'h1, 1'h0, 4, '{14'h6, 14'h5, 14'h4, 14'h6});
    load(1'h1, 2'h1, 16'h0009, 16'h0003, 16'h0005);
    burst(1'h1, 2'h1, 2'h1, 1'h1, 2, '{14'h9, 14'hC, 14'h0, 14'h0});
    burst(1'h1, 2'h1, 2'h1, 1'h0, 2, '{14'hA, 14'h8, 14'h0, 14'h0});
    $display("test circular done");
    load(1'h0, 2'h2, 16'h0001, 16'h0001, 16'h0000);
    mode(1'h0, 1'h0, 1'h1, 1'h1);
    mode(1'h1, 1'h0, 1'h0, 1'h0);
    mode(1'h1, 1'h0, 1'h1, 1'h1);
    mode(1'h1, 1'h1, 1'h0, 1'h1);
    burst(1'h0, 2'h2, 2'h2, 1'h0, 2, '{14'h2000, 14'h1000, 14'h0, 14'h0});
    rd(ADG_FILE_INDEX, 1'h0, 2'h2, 16'h0003);
    burst(1'h1, 2'h1, 2'h1, 1'h0, 1, '{14'hB, 14'h0, 14'h0, 14'h0});
    mode(1'h1, 1'h0, 1'h0, 1'h0);
    burst(1'h0, 2'h2, 2'h2, 1'h0, 1, '{14'h3, 14'h0, 14'h0, 14'h0});
    $display("test reversal done");
    print_verdict;
  end
endmodule
